/* File: ptf_pkg.sv */
package ptf_pkg;
    // ****************************************************
    // register byte offsets
    // ****************************************************
    localparam logic [7:0] ADDR_SYNC_SEL = 8'h00;
    localparam logic [7:0] ADDR_TRIG_CTL = 8'h04;
    localparam logic [7:0] ADDR_FAULT_CTL = 8'h08;
    localparam logic [7:0] ADDR_STRIG = 8'h0C;
    localparam logic [7:0] ADDR_FAULT_DATA = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_STATE = 8'h20;
    // ****************************************************
    // field positions
    // ****************************************************
    localparam int TRG_DIV_LSB = 12;
    localparam int TRG_DTM_BIT = 7;
    localparam int TRG_STRT_LSB = 0;
    localparam int FLT_SRC_LSB = 3;
    localparam int FLT_POL_BIT = 2;
    localparam int FLT_MOD_LSB = 0;
    localparam int STRIG_LSB = 3;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FCLR_BIT = 1;
    // ****************************************************
    // writable masks and reset values
    // ****************************************************
    localparam logic [15:0] MASK_SYNC_SEL = 16'h00FF;
    localparam logic [15:0] MASK_TRIG_CTL = 16'hF0BF;
    localparam logic [15:0] MASK_FAULT_CTL = 16'h00FF;
    localparam logic [15:0] MASK_STRIG = 16'hFFF8;
    localparam logic [15:0] MASK_FAULT_DATA = 16'h0003;
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [7:0] SYNC_PIN_MAX = 8'hB5;
    // ****************************************************
    // fault codes
    // ****************************************************
    localparam logic [4:0] FSRC_FAULT1 = 5'h01;
    localparam logic [4:0] FSRC_FAULT8 = 5'h08;
    localparam logic [4:0] FSRC_CMP1 = 5'h0D;
    localparam logic [4:0] FSRC_CMP2 = 5'h0E;
    typedef enum logic [1:0]
    {
        PTF_FM_LATCH = 2'b00,
        PTF_FM_CYCLE = 2'b01,
        PTF_FM_RSVD = 2'b10,
        PTF_FM_OFF = 2'b11
    } ptf_fmode_t;
    // interrupt bits: 0 primary trigger, 1 fault
    localparam int IRQ_W = 2;
endpackage

/* File: ptf_trig_if.sv */
interface ptf_trig_if;
    logic       enable;
    logic       cycle_start;
    logic [3:0] divider;
    logic [5:0] start_delay;
    logic       event_in;
    logic       trig_out;
    logic       delay_busy;
    modport ctl (output enable, cycle_start, divider, start_delay, event_in,
                 input trig_out, delay_busy);
    modport div (input enable, cycle_start, divider, start_delay, event_in,
                 output trig_out, delay_busy);
endinterface

/* File: ptf_trig_div.sv */
module ptf_trig_div
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    ptf_trig_if.div   tif
);
    import ptf_pkg::*;

    logic [3:0] event_cnt;
    logic [5:0] delay_cnt;
    logic       enable_d;
    logic       started;

    // ****************************************************
    // start delay after enable
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            enable_d  <= 1'b0;
            delay_cnt <= 6'h00;
            started   <= 1'b0;
        end
        else
        begin
            enable_d <= tif.enable;
            if (!tif.enable)
            begin
                started <= 1'b0;
            end
            else if (!enable_d)
            begin
                delay_cnt <= tif.start_delay;
                started   <= (tif.start_delay == 6'h00);
            end
            else if (!started && tif.cycle_start)
            begin
                if (delay_cnt <= 6'h01)
                begin
                    started <= 1'b1;
                end
                delay_cnt <= delay_cnt - 6'h01;
            end
        end
    end

    // ****************************************************
    // postscaler: one output per divider+1 events
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            event_cnt <= 4'h0;
        end
        else if (!tif.enable)
        begin
            event_cnt <= 4'h0;
        end
        else if (tif.event_in && started)
        begin
            if (event_cnt >= tif.divider)
            begin
                event_cnt <= 4'h0;
            end
            else
            begin
                event_cnt <= event_cnt + 4'h1;
            end
        end
    end

    assign tif.trig_out = tif.enable && started && tif.event_in &&
                          (event_cnt >= tif.divider);
    assign tif.delay_busy = tif.enable && !started;
endmodule

/* File: ptf_top.sv */
// How it works
// - divider N passes every N+1th trigger event
// - dual mode merges secondary into primary trigger
// - otherwise primary and secondary triggers stay separate
// - first primary trigger waits start-delay PWM cycles; secondary match is not delayed
// - source code selects fault 1-8 or comparators
// - polarity one means selected source active low
// - mode 11 ignores fault; 10 reserved
// - mode 01 overrides outputs cycle by cycle
// - mode 00 overrides outputs and latches
// - secondary match never raises trigger interrupt
module ptf_top
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // pwm core side, same clock
    input  wire logic         cycle_start,
    input  wire logic [12:0]  local_time,
    input  wire logic         primary_event,
    input  wire logic         pwm_high_in,
    input  wire logic         pwm_low_in,
    // pins from outside
    input  wire logic [7:0]   fault_pins,
    input  wire logic [1:0]   comparator_in,
    input  wire logic [181:1] remappable_pin,
    // outputs
    output logic              pwm_high_output,
    output logic              pwm_low_output,
    output logic              adc_trigger,
    output logic              adc_trigger2,
    output logic              sync_in2,
    output logic              pwm_master_enable,
    output logic              irq
);
    import ptf_pkg::*;

    logic [15:0]      sync_input2_pin_select;
    logic [15:0]      pwm_trigger_control;
    logic [15:0]      pwm_fault_limit_control;
    logic [15:0]      secondary_trigger_compare;
    logic [15:0]      fault_override_values;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0]       fault_s1;
    logic [7:0]       fault_s2;
    logic [1:0]       cmp_s1;
    logic [1:0]       cmp_s2;
    logic [181:1]     pin_s1;
    logic [181:1]     pin_s2;
    logic             fault_raw;
    logic             fault_active;
    logic             fault_latched;
    logic             fault_force;
    logic             secondary_match;
    logic             secondary_event;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic             fault_clear;
    logic [31:0]      next_rdata;
    ptf_fmode_t       fault_mode;

    ptf_trig_if tif ();

    ptf_trig_div u_div
    (
        .clk (clk),
        .rst (rst),
        .tif (tif)
    );

    // ****************************************************
    // apb access
    // ****************************************************
    // zero wait states: every access completes in its access phase
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign addr_ok = (paddr <= ADDR_STATE) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !addr_ok;
    assign fault_clear = wr_en && (paddr == ADDR_CTRL) &&
                         pwdata[CTRL_FCLR_BIT];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_input2_pin_select    <= RST_REG;
            pwm_trigger_control       <= RST_REG;
            pwm_fault_limit_control   <= RST_REG;
            secondary_trigger_compare <= RST_REG;
            fault_override_values     <= RST_REG;
            pwm_master_enable         <= 1'b0;
            irq_mask                  <= '0;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                ADDR_SYNC_SEL:
                    sync_input2_pin_select <= pwdata[15:0] & MASK_SYNC_SEL;
                ADDR_TRIG_CTL:
                    pwm_trigger_control <= pwdata[15:0] & MASK_TRIG_CTL;
                ADDR_FAULT_CTL:
                    pwm_fault_limit_control <= pwdata[15:0] & MASK_FAULT_CTL;
                ADDR_STRIG:
                    secondary_trigger_compare <= pwdata[15:0] & MASK_STRIG;
                ADDR_FAULT_DATA:
                    fault_override_values <= pwdata[15:0] & MASK_FAULT_DATA;
                ADDR_CTRL:
                    pwm_master_enable <= pwdata[CTRL_EN_BIT];
                ADDR_IRQ_MASK:
                    irq_mask <= pwdata[IRQ_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            ADDR_SYNC_SEL:   next_rdata[15:0] = sync_input2_pin_select;
            ADDR_TRIG_CTL:   next_rdata[15:0] = pwm_trigger_control;
            ADDR_FAULT_CTL:  next_rdata[15:0] = pwm_fault_limit_control;
            ADDR_STRIG:      next_rdata[15:0] = secondary_trigger_compare;
            ADDR_FAULT_DATA: next_rdata[15:0] = fault_override_values;
            ADDR_CTRL:       next_rdata[CTRL_EN_BIT] = pwm_master_enable;
            ADDR_IRQ_STAT:   next_rdata[IRQ_W-1:0] = irq_status;
            ADDR_IRQ_MASK:   next_rdata[IRQ_W-1:0] = irq_mask;
            ADDR_STATE:
                next_rdata[2:0] = {tif.delay_busy, fault_active, fault_latched};
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // read data registered during setup so it is stable in access phase
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= next_rdata;
        end
    end

    // ****************************************************
    // input synchronisers
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fault_s1 <= 8'h00;
            fault_s2 <= 8'h00;
            cmp_s1   <= 2'b00;
            cmp_s2   <= 2'b00;
            pin_s1   <= '0;
            pin_s2   <= '0;
        end
        else
        begin
            fault_s1 <= fault_pins;
            fault_s2 <= fault_s1;
            cmp_s1   <= comparator_in;
            cmp_s2   <= cmp_s1;
            pin_s1   <= remappable_pin;
            pin_s2   <= pin_s1;
        end
    end

    // ****************************************************
    // sync input 2 routing
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_in2 <= 1'b0;
        end
        else if (sync_input2_pin_select[7:0] == 8'h00 ||
                 sync_input2_pin_select[7:0] > SYNC_PIN_MAX)
        begin
            sync_in2 <= 1'b0;
        end
        else
        begin
            sync_in2 <= pin_s2[sync_input2_pin_select[7:0]];
        end
    end

    // ****************************************************
    // fault selection and override
    // ****************************************************
    assign fault_mode = ptf_fmode_t'(pwm_fault_limit_control[1:0]);

    always_comb
    begin
        logic [4:0] src;
        src = pwm_fault_limit_control[FLT_SRC_LSB +: 5];
        fault_raw = 1'b0;
        if (src >= FSRC_FAULT1 && src <= FSRC_FAULT8)
        begin
            fault_raw = fault_s2[3'(src - FSRC_FAULT1)];
        end
        else if (src == FSRC_CMP1)
        begin
            fault_raw = cmp_s2[0];
        end
        else if (src == FSRC_CMP2)
        begin
            fault_raw = cmp_s2[1];
        end
    end

    // polarity is assumed static while disabled
    assign fault_active = (pwm_fault_limit_control[FLT_POL_BIT] ?
                           !fault_raw : fault_raw) &&
                          (fault_mode == PTF_FM_LATCH ||
                           fault_mode == PTF_FM_CYCLE);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fault_latched <= 1'b0;
        end
        else if (fault_active && fault_mode == PTF_FM_LATCH)
        begin
            fault_latched <= 1'b1;
        end
        else if (fault_clear || !pwm_master_enable ||
                 fault_mode != PTF_FM_LATCH)
        begin
            fault_latched <= 1'b0;
        end
    end

    assign fault_force = fault_latched ||
                         (fault_active && fault_mode == PTF_FM_CYCLE);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pwm_high_output <= 1'b0;
            pwm_low_output  <= 1'b0;
        end
        else if (fault_force)
        begin
            pwm_high_output <= fault_override_values[1];
            pwm_low_output  <= fault_override_values[0];
        end
        else
        begin
            pwm_high_output <= pwm_high_in;
            pwm_low_output  <= pwm_low_in;
        end
    end

    // ****************************************************
    // triggers
    // ****************************************************
    assign secondary_match = pwm_master_enable &&
        (local_time == secondary_trigger_compare[STRIG_LSB +: 13]);
    assign secondary_event = secondary_match && cycle_start == 1'b0 ?
                             1'b1 : secondary_match;

    assign tif.enable      = pwm_master_enable;
    assign tif.cycle_start = cycle_start;
    assign tif.divider     = pwm_trigger_control[TRG_DIV_LSB +: 4];
    assign tif.start_delay = pwm_trigger_control[TRG_STRT_LSB +: 6];
    assign tif.event_in    = primary_event;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            adc_trigger  <= 1'b0;
            adc_trigger2 <= 1'b0;
        end
        else if (pwm_trigger_control[TRG_DTM_BIT])
        begin
            adc_trigger  <= tif.trig_out || secondary_event;
            adc_trigger2 <= 1'b0;
        end
        else
        begin
            adc_trigger  <= tif.trig_out;
            adc_trigger2 <= secondary_event;
        end
    end

    // ****************************************************
    // interrupts: set wins over write-one clear
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status <= '0;
        end
        else
        begin
            // only the primary path sets bit 0, never the secondary
            irq_status[0] <= tif.trig_out ||
                (irq_status[0] && !(wr_en && paddr == ADDR_IRQ_STAT &&
                                    pwdata[0]));
            irq_status[1] <= (fault_active && !fault_force) ||
                (fault_active && fault_mode != PTF_FM_OFF) ||
                (irq_status[1] && !(wr_en && paddr == ADDR_IRQ_STAT &&
                                    pwdata[1]));
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule

/* File: ptf_chk_asserts.sv */
module ptf_chk
    import ptf_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic         pready,
    input  wire logic [31:0]  prdata,
    input  wire logic         pslverr,
    // core side and pins
    input  wire logic         pwm_high_in,
    input  wire logic         pwm_low_in,
    input  wire logic [181:1] remappable_pin,
    // outputs
    input  wire logic         pwm_high_output,
    input  wire logic         pwm_low_output,
    input  wire logic         adc_trigger,
    input  wire logic         sync_in2,
    input  wire logic         pwm_master_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fm_off;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // shadow of the fault mode, so the bypass can be judged from ports
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fm_off <= 1'b0;
        end
        else if (psel && penable && pwrite && paddr == ADDR_FAULT_CTL)
        begin
            fm_off <= pwdata[1:0] == PTF_FM_OFF;
        end
    end

    sequence acc_s;
        psel && penable;
    endsequence
    sequence rd_s;
        acc_s ##0 !pwrite;
    endsequence
    sequence ctl_wr_s;
        acc_s ##0 pwrite && paddr == ADDR_CTRL;
    endsequence
    sequence pins_low_s;
        (remappable_pin == '0) [*4];
    endsequence

    pready_high_a: assert property (acc_s |-> pready)
        else $error("access phase without ready");
    bad_addr_a: assert property (acc_s ##0
        (paddr > 8'h20 || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access not refused");
    err_read_zero_a: assert property (rd_s ##0 pslverr |-> prdata == '0)
        else $error("refused read returned data");
    enable_set_a: assert property (ctl_wr_s |=>
        pwm_master_enable == $past(pwdata[0]))
        else $error("enable did not follow write");
    enable_hold_a: assert property (!(psel && penable && pwrite &&
        paddr == ADDR_CTRL) |=> $stable(pwm_master_enable))
        else $error("enable changed without write");
    enable_read_a: assert property (rd_s ##0 paddr == ADDR_CTRL |->
        prdata[0] == pwm_master_enable)
        else $error("enable read back wrong");
    sync_rsvd_a: assert property (rd_s ##0 paddr == ADDR_SYNC_SEL |->
        prdata[31:8] == 24'h0)
        else $error("reserved selector bits read nonzero");
    sync_ground_a: assert property (pins_low_s |=> !sync_in2)
        else $error("sync input high with all pins low");
    trig_pulse_a: assert property (adc_trigger |=> !adc_trigger)
        else $error("trigger wider than one cycle");
    // a latch left from mode 00 still forces the cycle after the switch
    fault_bypass_a: assert property (fm_off && $past(fm_off) &&
        $past(fm_off, 2) |->
        pwm_high_output == $past(pwm_high_in) &&
        pwm_low_output == $past(pwm_low_in))
        else $error("outputs altered with fault ignored");
endmodule

/* File: ptf_core_model.sv */
module ptf_core_model
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // stimulus control
    input  wire logic   ev_on,
    // pwm core side
    output logic        cycle_start,
    output logic [12:0] local_time,
    output logic        primary_event,
    output logic        pwm_high_in,
    output logic        pwm_low_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // eight-clock period keeps every count in the bench short
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            local_time <= 13'h0000;
        end
        else
        begin
            local_time <= {10'h000, local_time[2:0] + 3'h1};
        end
    end
    assign cycle_start   = !rst && local_time == 13'h0000;
    assign primary_event = ev_on && local_time == 13'h0003;
    // complementary pair: both high can only be an override
    assign pwm_high_in   = local_time < 13'h0004;
    assign pwm_low_in    = !pwm_high_in;
endmodule

/* File: pwm_trigger_fault_control_tb.sv */
module pwm_trigger_fault_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ptf_pkg::*;
    logic           clk, rst, psel, penable, pwrite, pready, pslverr;
    logic           cycle_start, primary_event, pwm_high_in, pwm_low_in;
    logic           pwm_high_output, pwm_low_output, adc_trigger;
    logic           adc_trigger2, sync_in2, pwm_master_enable, irq;
    logic           ev_on, serr;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata, rdat;
    logic [12:0]    local_time;
    logic [9:0]     flt;
    logic [181:1]   remappable_pin;
    int             bad_count, n_compared, n, a, b;
    logic [7:0]     ra [5] = '{ADDR_SYNC_SEL, ADDR_TRIG_CTL, ADDR_FAULT_CTL,
                               ADDR_STRIG, ADDR_FAULT_DATA};
    logic [15:0]    rm [5] = '{MASK_SYNC_SEL, MASK_TRIG_CTL, MASK_FAULT_CTL,
                               MASK_STRIG, MASK_FAULT_DATA};
    logic [7:0]     pins [4] = '{8'h01, 8'h05, SYNC_PIN_MAX, 8'h00};
    logic [3:0]     divs [3] = '{4'h0, 4'h3, 4'hF};
    logic [5:0]     dly [2] = '{6'h01, 6'h3F};

    ptf_top i_dut
    (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .cycle_start, .local_time, .primary_event,
        .pwm_high_in, .pwm_low_in, .fault_pins(flt[7:0]),
        .comparator_in(flt[9:8]), .remappable_pin, .pwm_high_output,
        .pwm_low_output, .adc_trigger, .adc_trigger2, .sync_in2,
        .pwm_master_enable, .irq
    );
    ptf_core_model i_core
    (
        .clk, .rst, .ev_on, .cycle_start, .local_time, .primary_event,
        .pwm_high_in, .pwm_low_in
    );

    // ****
    // bus and check tasks
    // ****
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge keeps two requests from sharing a time step
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(rdat, e);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic gap(output int k);
        k = 0;
        do @(posedge clk); while (adc_trigger !== 1'b1);
        do
        begin
            @(posedge clk);
            if (primary_event === 1'b1) k++;
        end while (adc_trigger !== 1'b1);
    endtask
    task automatic cnt(input int k, output int x, output int y);
        x = 0;
        y = 0;
        repeat (k)
        begin
            @(posedge clk);
            x += int'(adc_trigger === 1'b1);
            y += int'(adc_trigger2 === 1'b1);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        complete_run();
    end

    // ****
    // tests
    // ****
    initial
    begin
        {rst, bad_count, n_compared} = {1'b1, 64'h0};
        {psel, penable, pwrite, paddr, pwdata, ev_on, flt} = '0;
        remappable_pin = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
        begin
            rd(ra[i], 32'h0);
            wr(ra[i], 32'hFFFF_F0B5);
            rd(ra[i], {16'h0, 16'hF0B5 & rm[i]});
            wr(ra[i], 32'h0);
        end
        rd(8'h24, 32'h0);
        chk(serr, 1'b1);
        rd(8'h02, 32'h0);
        chk(serr, 1'b1);
        $display("done registers");
        foreach (pins[i])
        begin
            wr(ADDR_SYNC_SEL, {24'h0, pins[i]});
            remappable_pin <= (pins[i] == 8'h00) ? '1 :
                              181'h1 << (pins[i] - 8'h01);
            tick(5);
            chk(sync_in2, pins[i] != 8'h00);
            remappable_pin <= ~remappable_pin;
            tick(5);
            chk(sync_in2, 1'b0);
        end
        $display("done sync routing");
        ev_on <= 1'b1;
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, 32'h1);
        foreach (divs[i])
        begin
            wr(ADDR_TRIG_CTL, {16'h0, divs[i], 12'h000});
            gap(n);
            chk(n, int'(divs[i]) + 1);
        end
        $display("done divider");
        ev_on <= 1'b0;
        wr(ADDR_STRIG, 32'h30);
        wr(ADDR_TRIG_CTL, 32'h0);
        wr(ADDR_IRQ_STAT, 32'h3);
        do @(posedge clk); while (adc_trigger2 !== 1'b1);
        chk(local_time, 13'h0007);
        cnt(32, a, b);
        chk(a, 0);
        chk(b, 4);
        rd(ADDR_IRQ_STAT, 32'h0);
        wr(ADDR_TRIG_CTL, 32'h80);
        tick(8);
        cnt(32, a, b);
        chk(a, 4);
        chk(b, 0);
        rd(ADDR_IRQ_STAT, 32'h0);
        $display("done secondary");
        ev_on <= 1'b1;
        foreach (dly[i])
        begin
            wr(ADDR_CTRL, 32'h0);
            wr(ADDR_TRIG_CTL, {26'h0, dly[i]});
            do @(posedge clk); while (local_time !== 13'h0004);
            wr(ADDR_CTRL, 32'h1);
            n = 0;
            do
            begin
                @(posedge clk);
                if (cycle_start === 1'b1) n++;
            end while (adc_trigger !== 1'b1);
            chk(n, dly[i]);
        end
        $display("done start delay");
        ev_on <= 1'b0;
        wr(ADDR_FAULT_DATA, 32'h3);
        for (int i = 0; i < 10; i++)
        begin
            wr(ADDR_FAULT_CTL, ((i < 8 ? i + 1 : i + 5) << 3) | 1);
            flt <= ~(10'h1 << i);
            tick(5);
            chk(pwm_high_output & pwm_low_output, 1'b0);
            flt <= 10'h1 << i;
            tick(5);
            chk({pwm_high_output, pwm_low_output}, 2'b11);
            flt <= 10'h0;
            tick(10);
            chk(pwm_high_output & pwm_low_output, 1'b0);
        end
        wr(ADDR_FAULT_CTL, 32'h08);
        wr(ADDR_IRQ_STAT, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h2);
        flt <= 10'h001;
        tick(5);
        flt <= 10'h000;
        tick(10);
        chk({pwm_high_output, pwm_low_output}, 2'b11);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0);
        chk(irq, 1'b0);
        rd(ADDR_IRQ_STAT, 32'h2);
        rd(ADDR_STATE, 32'h1);
        wr(ADDR_CTRL, 32'h3);
        tick(3);
        chk(pwm_high_output & pwm_low_output, 1'b0);
        wr(ADDR_IRQ_STAT, 32'h2);
        rd(ADDR_IRQ_STAT, 32'h0);
        wr(ADDR_FAULT_CTL, 32'h0B);
        flt <= 10'h001;
        tick(5);
        chk(pwm_high_output & pwm_low_output, 1'b0);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_FAULT_CTL, 32'h0D);
        wr(ADDR_CTRL, 32'h1);
        flt <= 10'h3FF;
        tick(5);
        chk(pwm_high_output & pwm_low_output, 1'b0);
        flt <= 10'h3FE;
        tick(5);
        chk({pwm_high_output, pwm_low_output}, 2'b11);
        $display("done fault");
        complete_run();
    end
endmodule

bind ptf_top ptf_chk i_chk
(
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pwm_high_in, .pwm_low_in, .remappable_pin,
    .pwm_high_output, .pwm_low_output, .adc_trigger, .sync_in2,
    .pwm_master_enable
);
